/* File: logic/ccb_map.vh */
// Constants for the burst-mode coulomb counter control block.
// Assumes a 100 MHz core clock; included by ccb_burst_ctrl.v and by the testbench.
`ifndef CCB_MAP_VH
`define CCB_MAP_VH

// ****************************************
// Register offsets (APB byte addresses)
// ****************************************
`define CCB_OFF_CONFIG    12'h004
`define CCB_OFF_CHARGE    12'h00C
`define CCB_OFF_STATUS    12'h010
`define CCB_OFF_IRQ_STAT  12'h014
`define CCB_OFF_IRQ_MASK  12'h018

// ****************************************
// Field positions and reset values
// ****************************************
`define CCB_CFG_PRESC_MSB 3
`define CCB_CFG_VSEL_LSB  4
`define CCB_CFG_VSEL_MSB  6
`define CCB_CFG_VOVR_BIT  7
`define CCB_CFG_RESET     8'h00
`define CCB_CHARGE_RESET  8'h00
`define CCB_IRQ_PG_RISE   0
`define CCB_IRQ_PG_FALL   1
`define CCB_IRQ_AC_OVF    2
`define CCB_IRQ_CNT_OVF   3
`define CCB_IRQ_WIDTH     4

// ****************************************
// Timing
// ****************************************
`define CCB_CLK_MHZ       100
`define CCB_TFS_NS        11740
`define CCB_TFS_CYCLES    ((`CCB_TFS_NS * `CCB_CLK_MHZ) / 1000)

`endif

/* File: logic/ccb_burst_ctrl.v */
// Burst cycle sequencer with coulomb counter and APB register file.
// Assumes comparator inputs are asynchronous and pass two flops; APB runs on core_clk.
// How it works
// - Select pins 001..111 map to rising voltages
// - Sleep only after both phases and zero current
// - Switch D off until output near 1.2V
// - Power good rises at first sleep entry
// - Power good falls at 92 percent droop
// - Close A,C to peak, then B,D to zero
// - Time charge phase against full-scale on time
// - Add 8-bit charge at each A,C turn-on
// - Adder carry advances the 42-bit counter
// - Counter holds while asleep
// - 50-bit chain, top 8 bits readable
// - Prescaler zero reads full-length chain top
// - Prescaler 0..15 in config low bits, default 0
// - Charge byte at 03h, read/write, resets 00h
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "ccb_map.vh"

module ccb_burst_ctrl #(
    parameter TFS_CYCLES = `CCB_TFS_CYCLES
) (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [2:0]  outSelPin,
    input  wire        sleepCmpIn,
    input  wire        peakCurrentLimitIn,
    input  wire        zeroCurrentThresholdIn,
    input  wire        startupDoneIn,
    input  wire        droopCmpIn,
    output reg         switchA,
    output reg         switchB,
    output reg         switchC,
    output reg         switchD,
    output reg         asleep,
    output reg         power_good_flag,
    output reg  [2:0]  voltSelect,
    output wire        irqOut
);

    // ****************************************
    // States and local constants
    // ****************************************
    localparam [1:0] ST_SLEEP  = 2'b00;
    localparam [1:0] ST_CHARGE = 2'b01;
    localparam [1:0] ST_DUMP   = 2'b10;
    localparam [2:0] V_2P5 = 3'd1, V_2P8 = 3'd2, V_3P0 = 3'd3, V_3P3 = 3'd4;
    localparam [2:0] V_3P6 = 3'd5, V_4P5 = 3'd6, V_5P0 = 3'd7, V_1P8 = 3'd0;

    // Maps a select code to the voltage index; identity by design
    function [2:0] volt_of;
        input [2:0] code;
        begin
            case (code)
                3'b001:  volt_of = V_2P5;
                3'b010:  volt_of = V_2P8;
                3'b011:  volt_of = V_3P0;
                3'b100:  volt_of = V_3P3;
                3'b101:  volt_of = V_3P6;
                3'b110:  volt_of = V_4P5;
                3'b111:  volt_of = V_5P0;
                default: volt_of = V_1P8;
            endcase
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg [7:0] syncA_reg;
    reg [7:0] syncB_reg;
    // Pins are asynchronous; first stage feeds only the second
    always @(posedge core_clk) begin
        syncA_reg <= {outSelPin, sleepCmpIn, peakCurrentLimitIn, zeroCurrentThresholdIn,
                      startupDoneIn, droopCmpIn};
        syncB_reg <= syncA_reg;
    end
    wire [2:0] selPinS  = syncB_reg[7:5];
    wire       sleepReq = syncB_reg[4];
    wire       atPeak   = syncB_reg[3];
    wire       atZero   = syncB_reg[2];
    wire       outUp    = syncB_reg[1];
    wire       droop    = syncB_reg[0];

    // ****************************************
    // Registers
    // ****************************************
    reg  [7:0]  config_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [13:0] onCnt_reg;
    reg         acOvf_reg;
    reg  [49:0] chain_reg;
    reg         chainOvf_reg;
    reg         slept_reg;
    reg  [3:0]  irqStat_reg;
    reg  [3:0]  irqMask_reg;

    wire [3:0] presc    = config_reg[`CCB_CFG_PRESC_MSB:0];
    wire       acStart  = (state_reg != ST_CHARGE) && (state_next == ST_CHARGE);
    wire       acEnd    = (state_reg == ST_CHARGE) && (state_next != ST_CHARGE);
    wire       wrEn     = psel && penable && pwrite;
    wire       rdEn     = psel && penable && !pwrite;

    // ****************************************
    // Burst sequencer
    // ****************************************
    // Sleep only from the dump phase once current is zero
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_SLEEP:  if (!sleepReq) state_next = ST_CHARGE;
            ST_CHARGE: if (atPeak || onCnt_reg == TFS_CYCLES[13:0])
                           state_next = ST_DUMP;
            ST_DUMP:   if (atZero)
                           state_next = sleepReq ? ST_SLEEP : ST_CHARGE;
            default:   state_next = ST_SLEEP;
        endcase
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_SLEEP;
        end else begin
            state_reg <= state_next;
        end
    end

    // Switch drive registered; D held off until the output comes up
    always @(posedge core_clk) begin
        if (sys_rst) begin
            switchA <= 1'b0;
            switchB <= 1'b0;
            switchC <= 1'b0;
            switchD <= 1'b0;
            asleep  <= 1'b1;
        end else begin
            switchA <= (state_next == ST_CHARGE);
            switchC <= (state_next == ST_CHARGE);
            switchB <= (state_next == ST_DUMP);
            switchD <= (state_next == ST_DUMP) && outUp;
            asleep  <= (state_next == ST_SLEEP);
        end
    end

    // ****************************************
    // Charge measurement
    // ****************************************
    // Saturates at full scale and flags an on-time overflow
    always @(posedge core_clk) begin
        if (sys_rst) begin
            onCnt_reg <= 14'h0000;
            acOvf_reg <= 1'b0;
        end else begin
            acOvf_reg <= 1'b0;
            if (acStart) begin
                onCnt_reg <= 14'h0000;
            end else if (state_reg == ST_CHARGE && onCnt_reg != TFS_CYCLES[13:0]) begin
                onCnt_reg <= onCnt_reg + 14'h0001;
            end else if (state_reg == ST_CHARGE) begin
                acOvf_reg <= 1'b1;
            end
        end
    end

    // Ratio to full scale, as 8 bits (255 == full scale); quotient never tops 255
    wire [31:0] ratioWide = ({18'h0_0000, onCnt_reg} * 32'h0000_00FF) / TFS_CYCLES;
    wire [7:0]  chargeVal = ratioWide[7:0];
    reg  [7:0]  pendVal_reg;

    // ****************************************
    // Counter chain: 8-bit accumulator plus 42-bit ripple stage
    // ****************************************
    wire [8:0] accSum = {1'b0, chain_reg[7:0]} + {1'b0, pendVal_reg};
    wire [42:0] rippleInc = {1'b0, chain_reg[49:8]} + 43'h000_0000_0001;
    wire [5:0]  topLsb = 6'd42 - {2'b00, presc};
    wire [49:0] chainShift = chain_reg >> topLsb;
    wire [7:0]  chargeByte = chainShift[7:0];

    // Value measured in the last phase is added at the next A,C turn-on
    always @(posedge core_clk) begin
        if (sys_rst) begin
            chain_reg    <= 50'h0;
            pendVal_reg  <= 8'h00;
            chainOvf_reg <= 1'b0;
        end else begin
            chainOvf_reg <= 1'b0;
            if (acEnd) begin
                pendVal_reg <= chargeVal;
            end
            if (wrEn && paddr == `CCB_OFF_CHARGE) begin
                chain_reg <= {pwdata[7:0], 42'h0} >> presc;
            end else if (acStart) begin
                chain_reg[7:0] <= accSum[7:0];
                if (accSum[8]) begin
                    chain_reg[49:8] <= rippleInc[41:0];
                    chainOvf_reg    <= rippleInc[42];
                end
            end
        end
    end

    // ****************************************
    // Power good and voltage select
    // ****************************************
    always @(posedge core_clk) begin
        if (sys_rst) begin
            power_good_flag <= 1'b0;
            slept_reg       <= 1'b0;
            voltSelect      <= V_1P8;
        end else begin
            voltSelect <= config_reg[`CCB_CFG_VOVR_BIT] ?
                          volt_of(config_reg[`CCB_CFG_VSEL_MSB:`CCB_CFG_VSEL_LSB]) :
                          volt_of(selPinS);
            if (droop) begin
                power_good_flag <= 1'b0;
            end else if (!slept_reg && state_reg != ST_SLEEP && state_next == ST_SLEEP) begin
                power_good_flag <= 1'b1;
                slept_reg       <= 1'b1;
            end
        end
    end

    // ****************************************
    // APB slave and interrupts
    // ****************************************
    wire [3:0] irqEvt;
    assign irqEvt[`CCB_IRQ_PG_RISE] = !slept_reg && state_reg != ST_SLEEP && state_next == ST_SLEEP;
    assign irqEvt[`CCB_IRQ_PG_FALL] = droop && power_good_flag;
    assign irqEvt[`CCB_IRQ_AC_OVF]  = acOvf_reg;
    assign irqEvt[`CCB_IRQ_CNT_OVF] = chainOvf_reg;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irqOut  = |(irqStat_reg & irqMask_reg);

    // Set wins over write-one-to-clear in the same cycle
    always @(posedge core_clk) begin
        if (sys_rst) begin
            config_reg  <= `CCB_CFG_RESET;
            irqStat_reg <= 4'h0;
            irqMask_reg <= 4'h0;
        end else begin
            if (wrEn && paddr == `CCB_OFF_CONFIG) begin
                config_reg <= pwdata[7:0];
            end
            if (wrEn && paddr == `CCB_OFF_IRQ_MASK) begin
                irqMask_reg <= pwdata[3:0];
            end
            irqStat_reg <= (irqStat_reg & ~((wrEn && paddr == `CCB_OFF_IRQ_STAT) ?
                            pwdata[3:0] : 4'h0)) | irqEvt;
        end
    end

    // Read data registered in the setup cycle (psel high, penable low); unmapped reads zero
    always @(posedge core_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `CCB_OFF_CONFIG:   prdata <= {24'h00_0000, config_reg};
                `CCB_OFF_CHARGE:   prdata <= {24'h00_0000, chargeByte};
                `CCB_OFF_STATUS:   prdata <= {26'h000_0000, asleep, power_good_flag,
                                              voltSelect, 1'b0};
                `CCB_OFF_IRQ_STAT: prdata <= {28'h000_0000, irqStat_reg};
                `CCB_OFF_IRQ_MASK: prdata <= {28'h000_0000, irqMask_reg};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: dv/ccb_burst_monitor.sv */
// Checker for switch, sleep, flag and voltage outputs of the burst controller.
// Assumes a bind onto ccb_burst_ctrl; comparator inputs pass two sync flops.
`timescale 1ns/100ps
module ccb_burst_monitor #(
    parameter TFS_CYCLES = 1174
) (
    input wire        core_clk,
    input wire        sys_rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [2:0]  outSelPin,
    input wire        sleepCmpIn,
    input wire        peakCurrentLimitIn,
    input wire        zeroCurrentThresholdIn,
    input wire        startupDoneIn,
    input wire        droopCmpIn,
    input wire        switchA,
    input wire        switchB,
    input wire        switchC,
    input wire        switchD,
    input wire        asleep,
    input wire        power_good_flag,
    input wire [2:0]  voltSelect,
    input wire        irqOut
);
    // ****
    // Properties
    // ****
    // Margin of four covers synchroniser and state register delay
    localparam int CHG_MAX = TFS_CYCLES + 4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence chargeEnd; $fell(switchA); endsequence
    sequence dumpStart; switchB && !switchA && !switchC; endsequence
    chg_to_dump_a: assert property (chargeEnd |-> dumpStart)
        else $error("dump phase did not follow charge phase");
    chg_bounded_a: assert property ($rose(switchA) |-> ##[1:CHG_MAX] !switchA)
        else $error("charge phase outlived full-scale time");
    sleep_entry_a: assert property ($rose(asleep) |-> ($past(switchB) || $past(switchB, 2)))
        else $error("sleep entered outside a dump phase end");
    sleep_quiet_a: assert property (asleep |-> !(switchA || switchB || switchC || switchD))
        else $error("switch closed while asleep");
    d_held_a: assert property (!startupDoneIn [*5] |-> !switchD)
        else $error("switch D closed during start-up");
    pg_rise_a: assert property ($rose(power_good_flag) |-> asleep)
        else $error("power good rose outside sleep");
    pg_fall_a: assert property (droopCmpIn [*5] |-> !power_good_flag)
        else $error("power good held through droop");
    vsel_pins_a: assert property ($stable(outSelPin) [*6] |-> voltSelect == outSelPin)
        else $error("voltage select differs from pins");
endmodule

/* File: dv/ccb_power_stage.sv */
// Behavioural inductor stage: current ramps while charging, decays while dumping.
// Assumes switch levels high = closed; riseCycles sets how slow the ramp is.
`timescale 1ns/100ps
module ccb_power_stage (
    input  wire       core_clk,
    input  wire       switchA,
    input  wire       switchB,
    input  wire       switchC,
    input  wire [7:0] riseCycles,
    output logic      peakCurrentLimitIn,
    output logic      zeroCurrentThresholdIn
);
    localparam int FALL = 6;
    logic [7:0] phaseCnt = 8'h00;
    logic       aLast    = 1'b0;
    // Restart the ramp at every phase change, not just at idle
    always @(posedge core_clk) begin
        aLast <= switchA;
        if (switchA != aLast || !((switchA && switchC) || switchB)) begin
            phaseCnt <= 8'h00;
        end else begin
            phaseCnt <= phaseCnt + 8'h01;
        end
    end
    // Peak only while charging; current is zero whenever no phase runs
    assign peakCurrentLimitIn = switchA && switchC && phaseCnt >= riseCycles;
    assign zeroCurrentThresholdIn = !(switchA && switchC) && !(switchB && phaseCnt < FALL);
endmodule

/* File: dv/ccb_testbench.sv */
// Self-checking bench: APB master, comparator stimulus, power stage model.
// Assumes zero-wait APB slave and TFS_CYCLES shortened to 20.
`timescale 1ns/100ps
`include "ccb_map.vh"
module testbench;
    logic        core_clk = 1'b0, sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, irqOut, asleep, power_good_flag;
    logic        switchA, switchB, switchC, switchD;
    logic [2:0]  outSelPin = 3'h0, voltSelect;
    logic        sleepCmpIn = 1'b1, startupDoneIn = 1'b0, droopCmpIn = 1'b0;
    logic        peakCurrentLimitIn, zeroCurrentThresholdIn;
    logic [7:0]  riseCycles = 8'h0A;
    int          mismatches = 0, checkCount = 0;
    ccb_burst_ctrl #(.TFS_CYCLES(20)) DUT (.*);
    ccb_power_stage stage (.*);
    initial forever #5 core_clk = ~core_clk;
    // ****
    // Shared tasks
    // ****
    task chk(input logic [31:0] g, input logic [31:0] e);
        checkCount++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Request held until pready is sampled high, then released
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task tReset;
        apb(0, `CCB_OFF_CONFIG, 0); chk(rd, 0);
        apb(0, `CCB_OFF_CHARGE, 0); chk(rd, 0);
        apb(0, 12'h100, 0); chk(rd, 0);
        chk(pslverr, 0); chk(pready, 1);
        chk(power_good_flag, 0);
        apb(1, `CCB_OFF_CONFIG, 32'h0000_000F);
        apb(0, `CCB_OFF_CONFIG, 0); chk(rd, 32'h0000_000F);
        apb(1, `CCB_OFF_CONFIG, 0);
    endtask
    task tPins;
        for (int c = 0; c < 8; c++) begin
            outSelPin <= 3'(c);
            repeat (6) @(posedge core_clk);
            chk(voltSelect, 32'(c));
            apb(0, `CCB_OFF_STATUS, 0); chk(rd[3:1], 32'(c));
        end
    endtask
    task tBurst;
        sleepCmpIn <= 1'b0;
        repeat (300) if (!switchB) @(posedge core_clk);
        chk(switchD, 0);
        startupDoneIn <= 1'b1;
        repeat (300) if (!switchD) @(posedge core_clk);
        chk(switchD, 1);
        sleepCmpIn <= 1'b1;
        repeat (300) if (!asleep) @(posedge core_clk);
        @(negedge core_clk);
        chk(asleep, 1);
        chk(power_good_flag, 1);
        apb(0, `CCB_OFF_IRQ_STAT, 0); chk(rd[0], 1);
        @(negedge core_clk); chk(irqOut, 0);
        apb(1, `CCB_OFF_IRQ_MASK, 32'h0000_0001);
        @(negedge core_clk); chk(irqOut, 1);
        apb(1, `CCB_OFF_IRQ_STAT, 32'h0000_0001);
        @(negedge core_clk); chk(irqOut, 0);
    endtask
    // Charge byte edits while asleep, so the chain cannot move
    task tHold;
        apb(1, `CCB_OFF_CHARGE, 32'h0000_00A5);
        repeat (100) @(posedge core_clk);
        apb(0, `CCB_OFF_CHARGE, 0); chk(rd, 32'h0000_00A5);
        apb(1, `CCB_OFF_CONFIG, 32'h0000_000F);
        apb(0, `CCB_OFF_CHARGE, 0); chk(rd, 0);
        apb(1, `CCB_OFF_CHARGE, 32'h0000_003C);
        apb(0, `CCB_OFF_CHARGE, 0); chk(rd, 32'h0000_003C);
        apb(1, `CCB_OFF_CONFIG, 0);
        apb(0, `CCB_OFF_CHARGE, 0); chk(rd, 0);
    endtask
    // Slow ramp beyond full scale must time the charge phase out
    task tTimeout;
        riseCycles <= 8'h28;
        sleepCmpIn <= 1'b0;
        repeat (300) if (!switchB) @(posedge core_clk);
        apb(0, `CCB_OFF_IRQ_STAT, 0); chk(rd[2], 1);
        riseCycles <= 8'h0A;
        sleepCmpIn <= 1'b1;
        repeat (300) if (!asleep) @(posedge core_clk);
    endtask
    task tDroop;
        droopCmpIn <= 1'b1;
        repeat (20) if (power_good_flag) @(posedge core_clk);
        @(negedge core_clk); chk(power_good_flag, 0);
        apb(0, `CCB_OFF_IRQ_STAT, 0); chk(rd[1], 1);
        droopCmpIn <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        tReset; tPins; tBurst; tHold; tTimeout; tDroop;
        tally_and_finish;
    end
    // Whole run needs under two thousand cycles; allow far more
    initial begin
        #500000;
        mismatches++;
        tally_and_finish;
    end
endmodule
bind ccb_burst_ctrl ccb_burst_monitor #(.TFS_CYCLES(TFS_CYCLES)) mon (.*);
